// [hw/bsio_top.v]
// bus strobes, bus port and quasi-bidirectional ports of the microcomputer
//
// Overview of operation
// R1: external data write pulls write strobe low with data on bus port.
// R2: bus output latch instruction also pulses write strobe.
// R3: external data read pulls read strobe low; sampled byte returned to core.
// R4: strobed bus input instruction also pulses read strobe.
// R5: program fetch strobe only for external fetches, after address latch strobe.
// R6: address and opcode sit on port two low nibble before expander strobe falls.
// R7: expander write data sits on low nibble at expander strobe rise.
// R8: expander holds read data on low nibble across expander strobe rise.
// R9: 24 lines: bus port plus two 8-bit quasi-bidirectional ports.
// R10: quasi bit 1 is weak high or input; bit 0 drives strong low.
// R11: written port data stays latched; inputs sampled only when read.
// R12: external fetch puts high address on low nibble, latch restored after.
// R13: expander use destroys low nibble latch; expander read leaves lines input.
// R14: writing 1 gives a short strong pullup, then weak high.
// R15: reset sets all quasi lines weak high.
// R16: software writes 1 before using a quasi line as input.
// R17: external fetch drives low eight program counter bits on bus.
// R18: program memory holds instruction stable when fetch strobe rises.
// R19: bus floats when idle unless bus output latch left data.
// R20: bus set as whole byte; stays output until reset or external access.
// R21: fetch address: low 8 bits on bus, top 4 on low nibble.
// R22: one address latch strobe per machine cycle, address valid at its fall.
// R23: address latch strobe ends before read, write or fetch strobe starts.
`timescale 1ns/1ps
`include "bsio_regs.vh"

module bsio_top #(
    parameter [3:0] ALE_CYC = `BSIO_ALE_CYC,
    parameter [3:0] STB_CYC = `BSIO_STB_CYC,
    parameter [7:0] PU_CYC  = `BSIO_PU_CYC
) (
    // clock, reset, enable
    input  wire        CLK,
    input  wire        SYS_RST,
    input  wire        CE,
    // access requests from the core
    input  wire        CMD_VALID,
    output wire        CMD_READY,
    input  wire [3:0]  CMD_OP,
    input  wire [11:0] CMD_ADDR,
    input  wire [7:0]  CMD_DATA,
    // answers to the core
    output reg         RSP_VALID,
    output reg  [7:0]  RSP_DATA,
    // bus strobes
    output reg         ALE,
    output reg         WRITE_STROBE_N,
    output reg         READ_STROBE_N,
    output reg         PROGRAM_FETCH_STROBE_N,
    output reg         EXPANDER_STROBE,
    // true bidirectional bus port
    input  wire [7:0]  BUS_IN,
    output reg  [7:0]  BUS_OUT,
    output reg  [7:0]  BUS_OE,
    // quasi-bidirectional port 1
    input  wire [7:0]  P1_IN,
    output wire [7:0]  P1_OUT,
    output wire [7:0]  P1_OE,
    // quasi-bidirectional port 2
    input  wire [7:0]  P2_IN,
    output wire [7:0]  P2_OUT,
    output wire [7:0]  P2_OE
);

    reg  [2:0] state;
    reg  [3:0] cnt;
    reg  [3:0] op;
    reg  [11:0] addr;
    reg  [7:0] data;
    reg        bus_latched;
    reg  [7:0] bus_s1;
    reg  [7:0] bus_s2;
    reg  [7:0] bus_s3;
    reg  [7:0] bus_val;
    reg  [7:0] p1_mask;
    reg  [7:0] p2_mask;
    reg  [7:0] p1_wdata;
    reg  [7:0] p2_wdata;
    reg  [7:0] p2_ovr_en;
    reg  [7:0] p2_ovr_val;
    wire [7:0] p1_val;
    wire [7:0] p2_val;
    wire       ext_access;
    wire       is_exp;

    // requests are taken only between machine cycles
    assign CMD_READY  = CE & (state == `BSIO_ST_IDLE);
    assign ext_access = (CMD_OP == `BSIO_OP_FETCH_EXT) | (CMD_OP == `BSIO_OP_XDM_RD) |
                        (CMD_OP == `BSIO_OP_XDM_WR);
    assign is_exp     = (op == `BSIO_OP_EXP_RD) | (op == `BSIO_OP_EXP_WR);

    // bus pins pass three flops; a level counts once the last two agree
    always @(posedge CLK) begin
        if (SYS_RST) begin
            bus_s1  <= 8'h00;
            bus_s2  <= 8'h00;
            bus_s3  <= 8'h00;
            bus_val <= 8'h00;
        end else if (CE) begin
            bus_s1 <= BUS_IN;
            bus_s2 <= bus_s1;
            bus_s3 <= bus_s2;
            if (bus_s2 == bus_s3) begin
                bus_val <= bus_s3;
            end
        end
    end

    // machine cycle sequencer: address latch phase, hold, strobe, finish
    always @(posedge CLK) begin
        if (SYS_RST) begin
            state                  <= `BSIO_ST_IDLE;
            cnt                    <= 4'h0;
            op                     <= 4'h0;
            addr                   <= 12'h000;
            data                   <= 8'h00;
            ALE                    <= 1'b0;
            WRITE_STROBE_N         <= 1'b1;
            READ_STROBE_N          <= 1'b1;
            PROGRAM_FETCH_STROBE_N <= 1'b1;
            EXPANDER_STROBE        <= 1'b1;
            BUS_OUT                <= 8'h00;
            BUS_OE                 <= 8'h00;
            bus_latched            <= 1'b0;  // bus floats after reset, see R20
            RSP_VALID              <= 1'b0;
            RSP_DATA               <= 8'h00;
            p1_mask                <= 8'h00;
            p2_mask                <= 8'h00;
            p1_wdata               <= `BSIO_QP_RST;
            p2_wdata               <= `BSIO_QP_RST;
            p2_ovr_en              <= 8'h00;
            p2_ovr_val             <= 8'h00;
        end else if (CE) begin
            RSP_VALID <= 1'b0;
            p1_mask   <= 8'h00;
            p2_mask   <= 8'h00;
            case (state)
                `BSIO_ST_IDLE: begin
                    if (CMD_VALID) begin
                        op    <= CMD_OP;
                        addr  <= CMD_ADDR;
                        data  <= CMD_DATA;
                        ALE   <= 1'b1;                 // one pulse per machine cycle, see R22
                        cnt   <= ALE_CYC - 4'h1;
                        state <= `BSIO_ST_ALE;
                        // expander read sets the latch now; its pullup pulse is over before release, see R13
                        p2_mask  <= (CMD_OP == `BSIO_OP_EXP_RD) ? `BSIO_NIB_MASK : 8'h00;
                        p2_wdata <= `BSIO_QP_RST;
                        if (ext_access) begin
                            // low address byte on bus; external access ends latched mode
                            BUS_OUT     <= CMD_ADDR[7:0];   // see R17
                            BUS_OE      <= 8'hFF;
                            bus_latched <= 1'b0;            // see R20
                        end
                        if (CMD_OP == `BSIO_OP_FETCH_EXT) begin
                            // top four address bits hide the nibble latch, see R12
                            p2_ovr_en  <= `BSIO_NIB_MASK;
                            p2_ovr_val <= {4'h0, CMD_ADDR[`BSIO_PCHI_HI:`BSIO_PCHI_LO]}; // see R21
                        end
                    end
                end
                `BSIO_ST_ALE: begin
                    if (cnt == 4'h0) begin
                        // address stays driven across the falling edge
                        ALE   <= 1'b0;                 // see R22
                        state <= `BSIO_ST_HOLD;
                        if (is_exp) begin
                            // address and opcode settle before the strobe falls
                            p2_ovr_en  <= `BSIO_NIB_MASK;
                            p2_ovr_val <= {4'h0, addr[`BSIO_NIB_HI:`BSIO_NIB_LO]}; // see R6
                        end
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                `BSIO_ST_HOLD: begin
                    // strobes start only after the latch strobe has fallen, see R23
                    cnt   <= STB_CYC - 4'h1;
                    state <= `BSIO_ST_STB;
                    case (op)
                        `BSIO_OP_FETCH_EXT: begin
                            PROGRAM_FETCH_STROBE_N <= 1'b0;   // never for internal fetch, see R5
                            BUS_OE                 <= 8'h00;
                        end
                        `BSIO_OP_XDM_RD: begin
                            READ_STROBE_N <= 1'b0;            // see R3
                            BUS_OE        <= 8'h00;
                        end
                        `BSIO_OP_BIS: begin
                            READ_STROBE_N <= 1'b0;            // see R4
                        end
                        `BSIO_OP_XDM_WR, `BSIO_OP_BOL: begin
                            WRITE_STROBE_N <= 1'b0;           // see R1 and R2
                            BUS_OUT        <= data;
                            BUS_OE         <= 8'hFF;
                        end
                        `BSIO_OP_EXP_RD, `BSIO_OP_EXP_WR: begin
                            EXPANDER_STROBE <= 1'b0;          // see R6
                        end
                        default: begin
                            cnt <= STB_CYC - 4'h1;
                        end
                    endcase
                end
                `BSIO_ST_STB: begin
                    if (cnt == 4'h0) begin
                        // sample at the same edge that raises the strobes
                        WRITE_STROBE_N         <= 1'b1;
                        READ_STROBE_N          <= 1'b1;
                        PROGRAM_FETCH_STROBE_N <= 1'b1;
                        EXPANDER_STROBE        <= 1'b1;   // write data still driven, see R7
                        state                  <= `BSIO_ST_END;
                        case (op)
                            `BSIO_OP_FETCH_EXT, `BSIO_OP_XDM_RD, `BSIO_OP_BIS: begin
                                RSP_DATA <= bus_val;      // see R3 and R18
                            end
                            `BSIO_OP_EXP_RD: begin
                                RSP_DATA <= {4'h0, p2_val[`BSIO_NIB_HI:`BSIO_NIB_LO]}; // see R8
                            end
                            `BSIO_OP_P1_RD: begin
                                RSP_DATA <= p1_val;       // sampled only now, see R11
                            end
                            `BSIO_OP_P2_RD: begin
                                RSP_DATA <= p2_val;
                            end
                            default: begin
                                RSP_DATA <= 8'h00;
                            end
                        endcase
                    end else begin
                        cnt <= cnt - 4'h1;
                        if (cnt == STB_CYC - 4'h1) begin
                            // first strobe cycle: swap the address nibble for data or release
                            if (op == `BSIO_OP_EXP_WR) begin
                                p2_ovr_val <= {4'h0, data[`BSIO_NIB_HI:`BSIO_NIB_LO]}; // see R7
                            end else if (op == `BSIO_OP_EXP_RD) begin
                                p2_ovr_en <= 8'h00;
                            end
                        end
                    end
                end
                `BSIO_ST_END: begin
                    RSP_VALID <= 1'b1;
                    state     <= `BSIO_ST_IDLE;
                    p2_ovr_en <= 8'h00;                   // nibble latch shows again, see R12
                    if (op == `BSIO_OP_BOL) begin
                        bus_latched <= 1'b1;               // whole byte stays driven, see R20
                    end else if (!bus_latched) begin
                        BUS_OE <= 8'h00;                   // float when idle, see R19
                    end
                    case (op)
                        `BSIO_OP_EXP_WR: begin
                            // expander value replaces the nibble latch, see R13
                            p2_mask  <= `BSIO_NIB_MASK;
                            p2_wdata <= {4'hF, data[`BSIO_NIB_HI:`BSIO_NIB_LO]};
                        end
                        `BSIO_OP_P1_WR: begin
                            p1_mask  <= 8'hFF;                 // see R11
                            p1_wdata <= data;
                        end
                        `BSIO_OP_P2_WR: begin
                            p2_mask  <= 8'hFF;
                            p2_wdata <= data;
                        end
                        default: begin
                            p1_mask <= 8'h00;
                        end
                    endcase
                end
                default: begin
                    state <= `BSIO_ST_IDLE;
                end
            endcase
        end
    end

    // two quasi-bidirectional ports; with the bus they make 24 lines, see R9
    bsio_qport #(
        .W       (8),
        .PU_CYC  (PU_CYC)
    ) u_port1 (
        .clk     (CLK),
        .rst     (SYS_RST),
        .ce      (CE),
        .wr_mask (p1_mask),
        .wr_data (p1_wdata),
        .ovr_en  (8'h00),
        .ovr_val (8'h00),
        .pin_in  (P1_IN),
        .pin_out (P1_OUT),
        .pin_oe  (P1_OE),
        .pin_val (p1_val)
    );

    // port 2 low nibble is shared with fetch address and expander traffic
    bsio_qport #(
        .W       (8),
        .PU_CYC  (PU_CYC)
    ) u_port2 (
        .clk     (CLK),
        .rst     (SYS_RST),
        .ce      (CE),
        .wr_mask (p2_mask),
        .wr_data (p2_wdata),
        .ovr_en  (p2_ovr_en),
        .ovr_val (p2_ovr_val),
        .pin_in  (P2_IN),
        .pin_out (P2_OUT),
        .pin_oe  (P2_OE),
        .pin_val (p2_val)
    );

endmodule

// [hw/bsio_regs.vh]
// constants for the bus strobe and i/o port block
`ifndef BSIO_REGS_VH
`define BSIO_REGS_VH

// access operations requested by the core
`define BSIO_OP_FETCH_INT 4'h0
`define BSIO_OP_FETCH_EXT 4'h1
`define BSIO_OP_XDM_RD    4'h2
`define BSIO_OP_XDM_WR    4'h3
`define BSIO_OP_BOL       4'h4
`define BSIO_OP_BIS       4'h5
`define BSIO_OP_EXP_RD    4'h6
`define BSIO_OP_EXP_WR    4'h7
`define BSIO_OP_P1_WR     4'h8
`define BSIO_OP_P2_WR     4'h9
`define BSIO_OP_P1_RD     4'hA
`define BSIO_OP_P2_RD     4'hB

// machine cycle sequencer states
`define BSIO_ST_IDLE 3'h0
`define BSIO_ST_ALE  3'h1
`define BSIO_ST_HOLD 3'h2
`define BSIO_ST_STB  3'h3
`define BSIO_ST_END  3'h4

// timing counts in clock cycles
`define BSIO_ALE_CYC 4'h2
`define BSIO_STB_CYC 4'h6
`define BSIO_PU_CYC  8'h02

// reset values and field positions
`define BSIO_QP_RST    8'hFF
`define BSIO_NIB_MASK  8'h0F
`define BSIO_NIB_LO    0
`define BSIO_NIB_HI    3
`define BSIO_PCHI_LO   8
`define BSIO_PCHI_HI   11

`endif

// [hw/bsio_qport.v]
// quasi-bidirectional 8-line port with latches, pullup pulse and input synchronisers
`timescale 1ns/1ps
`include "bsio_regs.vh"

module bsio_qport #(
    parameter       W      = 8,
    parameter [7:0] PU_CYC = `BSIO_PU_CYC
) (
    // clock, reset, enable
    input  wire         clk,
    input  wire         rst,
    input  wire         ce,
    // latch writes from the sequencer
    input  wire [W-1:0] wr_mask,
    input  wire [W-1:0] wr_data,
    // temporary strong drive that hides the latch
    input  wire [W-1:0] ovr_en,
    input  wire [W-1:0] ovr_val,
    // pins
    input  wire [W-1:0] pin_in,
    output wire [W-1:0] pin_out,
    output wire [W-1:0] pin_oe,
    // filtered pin level from the input synchroniser
    output wire [W-1:0] pin_val
);

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg       s1;
            reg       s2;
            reg       s3;
            reg       stable;
            reg       lat;
            reg [7:0] pu_cnt;

            // latch, pullup pulse and three-stage input filter per line
            always @(posedge clk) begin
                if (rst) begin
                    s1     <= 1'b1;
                    s2     <= 1'b1;
                    s3     <= 1'b1;
                    stable <= 1'b1;
                    lat    <= 1'b1;     // weak high input after reset, see R15
                    pu_cnt <= 8'h00;
                end else if (ce) begin
                    s1 <= pin_in[i];
                    s2 <= s1;
                    s3 <= s2;
                    // inputs are not latched, only filtered, see R11
                    if (s2 == s3) begin
                        stable <= s3;
                    end
                    if (wr_mask[i]) begin
                        lat <= wr_data[i];                  // held until rewritten, see R11
                        pu_cnt <= wr_data[i] ? PU_CYC : 8'h00; // brief strong high, see R14
                    end else if (pu_cnt != 8'h00) begin
                        pu_cnt <= pu_cnt - 8'h01;
                    end
                end
            end

            // a stored 0 sinks hard; a stored 1 is weak except in the pullup pulse, see R10
            assign pin_out[i] = ovr_en[i] ? ovr_val[i] : lat;
            assign pin_oe[i]  = ovr_en[i] | ~lat | (pu_cnt != 8'h00);
            assign pin_val[i] = stable;
        end
    endgenerate

endmodule

// [sim/bsio_top_monitor.sv]
// assertion checker for the bus strobe and port block
`timescale 1ns/1ps
`include "bsio_regs.vh"
module bsio_top_monitor #(
    parameter [3:0] ALE_CYC = `BSIO_ALE_CYC,
    parameter [3:0] STB_CYC = `BSIO_STB_CYC,
    parameter [7:0] PU_CYC  = `BSIO_PU_CYC
) (
    // clock and control
    input wire        CLK,
    input wire        SYS_RST,
    input wire        CE,
    // command and answer
    input wire        CMD_VALID,
    input wire        CMD_READY,
    input wire [3:0]  CMD_OP,
    input wire [11:0] CMD_ADDR,
    input wire [7:0]  CMD_DATA,
    input wire        RSP_VALID,
    input wire [7:0]  RSP_DATA,
    // strobes
    input wire        ALE,
    input wire        WRITE_STROBE_N,
    input wire        READ_STROBE_N,
    input wire        PROGRAM_FETCH_STROBE_N,
    input wire        EXPANDER_STROBE,
    // pins
    input wire [7:0]  BUS_IN,
    input wire [7:0]  BUS_OUT,
    input wire [7:0]  BUS_OE,
    input wire [7:0]  P1_IN,
    input wire [7:0]  P1_OUT,
    input wire [7:0]  P1_OE,
    input wire [7:0]  P2_IN,
    input wire [7:0]  P2_OUT,
    input wire [7:0]  P2_OE
);
    localparam int RSP_DLY = ALE_CYC + STB_CYC + 3;
    // a request counts only when it is taken
    wire take = CMD_VALID && CMD_READY;
    wire ext  = take && CMD_OP == `BSIO_OP_FETCH_EXT;
    // frozen clock enable stretches every sequence, so it disables the checks
    default clocking @(posedge CLK); endclocking
    default disable iff (SYS_RST || !CE);

    AST_ALE_PULSE: assert property (take |=> ALE ##1 ALE ##1 !ALE)
        else $error("address strobe pulse has wrong length");
    AST_RSP_TIME: assert property (take |-> ##RSP_DLY (RSP_VALID && CMD_READY))
        else $error("answer not on time");
    AST_FETCH_STB: assert property (ext |=> PROGRAM_FETCH_STROBE_N[*3] ##1 !PROGRAM_FETCH_STROBE_N[*6]
        ##1 PROGRAM_FETCH_STROBE_N)
        else $error("fetch strobe shape wrong");
    AST_NO_INT_STB: assert property (take && CMD_OP == `BSIO_OP_FETCH_INT |=>
        (PROGRAM_FETCH_STROBE_N && READ_STROBE_N && WRITE_STROBE_N)[*7])
        else $error("strobe during internal fetch");
    AST_WR_STB: assert property (take && (CMD_OP == 4'h3 || CMD_OP == 4'h4) |-> ##4
        (!WRITE_STROBE_N && BUS_OE == 8'hFF && BUS_OUT == $past(CMD_DATA, 4)))
        else $error("write strobe without data");
    AST_RD_STB: assert property (take && (CMD_OP == 4'h2 || CMD_OP == 4'h5) |-> ##4
        !READ_STROBE_N[*6] ##1 READ_STROBE_N)
        else $error("read strobe shape wrong");
    AST_FETCH_ADDR: assert property (ext |=> BUS_OE == 8'hFF && BUS_OUT == $past(CMD_ADDR[7:0])
        && P2_OE[3:0] == 4'hF && P2_OUT[3:0] == $past(CMD_ADDR[11:8]))
        else $error("fetch address not on pins");
    AST_RD_FLOAT: assert property (take && CMD_OP == 4'h2 |-> ##4 BUS_OE == 8'h00)
        else $error("bus driven during read");
    AST_EXP_FALL: assert property ($fell(EXPANDER_STROBE) |->
        $stable(P2_OUT[3:0]) && P2_OE[3:0] == 4'hF)
        else $error("expander nibble not ready at strobe fall");
    AST_EXP_WR: assert property (take && CMD_OP == `BSIO_OP_EXP_WR |-> ##10
        ($rose(EXPANDER_STROBE) && P2_OUT[3:0] == $past(CMD_DATA[3:0], 10)))
        else $error("expander write data missing at rise");
    AST_RST_STATE: assert property ($past(SYS_RST) |-> P1_OE == 8'h00 && P2_OE == 8'h00
        && P1_OUT == 8'hFF && P2_OUT == 8'hFF && BUS_OE == 8'h00 && !ALE)
        else $error("port state after reset wrong");
    AST_QP_PULSE: assert property (take && CMD_OP == `BSIO_OP_P1_WR |-> ##12 P1_OE == 8'hFF
        ##2 P1_OE == ~$past(CMD_DATA, 14))
        else $error("port pullup pulse wrong");
endmodule

// [sim/bsio_ext_model.sv]
// external memory, program store and port expander seen from the pins
`timescale 1ns/1ps
module bsio_ext_model (
    input  wire       clk,
    input  wire       ale,
    input  wire       wr_n,
    input  wire       rd_n,
    input  wire       fetch_n,
    input  wire       exp_stb,
    input  wire [7:0] bus_out,
    input  wire [7:0] bus_oe,
    input  wire [3:0] nib_out,
    input  wire [3:0] nib_oe,
    output wire [7:0] bus_pin,
    output wire [3:0] nib_pin
);
    reg  [7:0] mem [0:255];
    reg  [3:0] xreg [0:3];
    reg  [7:0] adr;
    reg  [7:0] last = 8'h00;
    reg  [3:0] xcmd;
    // answer only into a released bus, never fight the device
    wire       rd_on  = (!rd_n || !fetch_n) && bus_oe == 8'h00;
    wire [7:0] rd_dat = !fetch_n ? (adr ^ 8'h96) : mem[adr];
    wire       x_on   = !exp_stb && nib_oe == 4'h0;
    // address captured at the falling address strobe
    always @(negedge ale) adr = bus_out;
    // data written at the end of the write strobe
    always @(posedge wr_n) mem[adr] = bus_out;
    // expander takes command at fall, write nibble at rise
    always @(negedge exp_stb) xcmd = nib_out;
    always @(posedge exp_stb) if (nib_oe == 4'hF) xreg[xcmd[1:0]] = nib_out;
    // floating bus shows the inverse of its last value, so stale data never matches
    assign bus_pin = (bus_oe != 8'h00) ? bus_out : rd_on ? rd_dat : ~last;
    assign nib_pin = (nib_oe & nib_out) | (~nib_oe & (x_on ? xreg[xcmd[1:0]] : 4'hF));
    always @(posedge clk) if (rd_on || bus_oe != 8'h00) last <= bus_pin;
endmodule

// [sim/bsio_top_bench.sv]
// self-checking bench for the bus strobe and port block
`timescale 1ns/1ps
`include "bsio_regs.vh"
module bsio_top_bench;
    reg         clk = 1'b0;
    reg         sys_rst = 1'b1;
    reg         cmd_valid = 1'b0;
    reg  [3:0]  cmd_op = 4'h0;
    reg  [11:0] cmd_addr = 12'h000;
    reg  [7:0]  cmd_data = 8'h00;
    reg  [7:0]  p1_low = 8'h00;
    reg  [7:0]  rsp;
    integer     bad_count = 0;
    integer     n_tests = 0;
    integer     i;
    wire        cmd_ready, rsp_valid, ale, wr_n, rd_n, fetch_n, exp_stb;
    wire [7:0]  rsp_data, bus_out, bus_oe, bus_pin, p1_out, p1_oe, p2_out, p2_oe;
    wire [3:0]  nib_pin;
    // pins with weak high where nobody drives strongly
    wire [7:0]  p1_pin = (p1_oe & p1_out) | (~p1_oe & ~p1_low);
    wire [7:0]  p2_pin = {(p2_oe[7:4] & p2_out[7:4]) | ~p2_oe[7:4], nib_pin};

    always #10 clk = ~clk;

    bsio_top u_dut (
        .CLK(clk), .SYS_RST(sys_rst), .CE(1'b1),
        .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op),
        .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
        .ALE(ale), .WRITE_STROBE_N(wr_n), .READ_STROBE_N(rd_n),
        .PROGRAM_FETCH_STROBE_N(fetch_n), .EXPANDER_STROBE(exp_stb),
        .BUS_IN(bus_pin), .BUS_OUT(bus_out), .BUS_OE(bus_oe),
        .P1_IN(p1_pin), .P1_OUT(p1_out), .P1_OE(p1_oe),
        .P2_IN(p2_pin), .P2_OUT(p2_out), .P2_OE(p2_oe)
    );

    bsio_ext_model u_ext (
        .clk(clk), .ale(ale), .wr_n(wr_n), .rd_n(rd_n), .fetch_n(fetch_n), .exp_stb(exp_stb),
        .bus_out(bus_out), .bus_oe(bus_oe), .nib_out(p2_out[3:0]), .nib_oe(p2_oe[3:0]),
        .bus_pin(bus_pin), .nib_pin(nib_pin)
    );

    task final_report;
        begin
            $display("checks %0d mismatches %0d", n_tests, bad_count);
            if (bad_count == 0 && n_tests > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // one request, entered at a falling edge; returns in the answer cycle
    task do_op(input [3:0] op, input [11:0] a, input [7:0] d);
        integer k;
        begin
            k = 0;
            cmd_valid = 1'b1;
            cmd_op = op;
            cmd_addr = a;
            cmd_data = d;
            while (cmd_ready !== 1'b1 && k < 40) begin
                @(negedge clk);
                k = k + 1;
            end
            @(negedge clk);
            cmd_valid = 1'b0;
            while (rsp_valid !== 1'b1 && k < 40) begin
                @(negedge clk);
                k = k + 1;
            end
            if (k >= 40) begin
                bad_count = bad_count + 1;
                final_report;
            end
            rsp = rsp_data;
        end
    endtask

    task do_reset;
        begin
            sys_rst = 1'b1;
            repeat (2) @(negedge clk);
            sys_rst = 1'b0;
        end
    endtask

    task t_reset;
        begin
            chk(p1_out & p2_out, 8'hFF);
            chk(p1_oe | p2_oe | bus_oe, 8'h00);
            chk({3'h0, ale, wr_n, rd_n, fetch_n, exp_stb}, 8'h0F);
            do_op(`BSIO_OP_P1_RD, 12'h000, 8'h00);
            chk(rsp, 8'hFF);
            $display("reset state done");
        end
    endtask

    task t_xdm;
        begin
            for (i = 0; i < 3; i = i + 1)
                do_op(4'h3, i * 127, 8'hC3 ^ (i * 127));
            for (i = 0; i < 3; i = i + 1) begin
                do_op(4'h2, i * 127, 8'h00);
                chk(rsp, 8'hC3 ^ (i * 127));
            end
            chk(bus_oe, 8'h00);
            $display("external data moves done");
        end
    endtask

    task t_fetch;
        begin
            do_op(`BSIO_OP_P2_WR, 12'h000, 8'hA5);
            do_op(`BSIO_OP_FETCH_EXT, 12'h3C1, 8'h00);
            chk(rsp, 8'hC1 ^ 8'h96);
            do_op(`BSIO_OP_FETCH_INT, 12'h123, 8'h00);
            do_op(`BSIO_OP_P2_RD, 12'h000, 8'h00);
            chk(rsp, 8'hA5);
            $display("fetch done");
        end
    endtask

    task t_bus_latch;
        begin
            do_op(4'h4, 12'h000, 8'h3C);
            repeat (3) @(negedge clk);
            chk(bus_pin & bus_oe, 8'h3C);
            do_op(4'h5, 12'h000, 8'h00);
            chk(rsp, 8'h3C);
            chk(bus_oe, 8'hFF);
            do_op(4'h2, 12'h0FE, 8'h00);
            chk(rsp, 8'h3D);
            chk(bus_oe, 8'h00);
            $display("bus latch done");
        end
    endtask

    task t_quasi;
        begin
            // ones written first so the upper lines can serve as inputs
            do_op(`BSIO_OP_P1_WR, 12'h000, 8'hF0);
            repeat (4) @(negedge clk);
            chk(p1_oe, 8'h0F);
            p1_low = 8'h20;
            do_op(`BSIO_OP_P1_RD, 12'h000, 8'h00);
            chk(rsp, 8'hD0);
            p1_low = 8'h00;
            do_op(`BSIO_OP_P1_RD, 12'h000, 8'h00);
            chk(rsp, 8'hF0);
            $display("quasi port done");
        end
    endtask

    task t_expander;
        begin
            do_op(`BSIO_OP_EXP_WR, 12'h005, 8'h09);
            do_op(`BSIO_OP_EXP_RD, 12'h001, 8'h00);
            chk({4'h0, rsp[3:0]}, 8'h09);
            do_op(`BSIO_OP_P2_RD, 12'h000, 8'h00);
            chk({4'h0, rsp[3:0]}, 8'h0F);
            chk({4'h0, p2_oe[3:0]}, 8'h00);
            $display("expander done");
        end
    endtask

    initial begin
        do_reset;
        t_reset;
        t_xdm;
        t_fetch;
        t_bus_latch;
        t_quasi;
        t_expander;
        do_op(4'h4, 12'h000, 8'h99);
        do_reset;
        t_reset;
        final_report;
    end
endmodule

bind bsio_top bsio_top_monitor #(.ALE_CYC(ALE_CYC), .STB_CYC(STB_CYC), .PU_CYC(PU_CYC)) u_mon (
    .CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
    .CMD_OP(CMD_OP), .CMD_ADDR(CMD_ADDR), .CMD_DATA(CMD_DATA), .RSP_VALID(RSP_VALID),
    .RSP_DATA(RSP_DATA), .ALE(ALE), .WRITE_STROBE_N(WRITE_STROBE_N), .READ_STROBE_N(READ_STROBE_N),
    .PROGRAM_FETCH_STROBE_N(PROGRAM_FETCH_STROBE_N), .EXPANDER_STROBE(EXPANDER_STROBE),
    .BUS_IN(BUS_IN), .BUS_OUT(BUS_OUT), .BUS_OE(BUS_OE), .P1_IN(P1_IN), .P1_OUT(P1_OUT),
    .P1_OE(P1_OE), .P2_IN(P2_IN), .P2_OUT(P2_OUT), .P2_OE(P2_OE)
);
